// *** src/nvm_map.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the byte memory block
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// ----------------------------------------------------------------
// Register placement
// ----------------------------------------------------------------
`define NVM_SECTOR_DIRECT 8'h00
`define NVM_SECTOR_CTRL 8'h01
`define NVM_ADDR_OFF 8'h2c
`define NVM_DATA_OFF 8'h2d
`define NVM_CTRL_OFF 8'h40

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define NVM_CTRL_PROGRAM_PERMIT 3
`define NVM_CTRL_WRITE_TRIGGER 2
`define NVM_CTRL_FETCH_PERMIT 1
`define NVM_CTRL_READ_TRIGGER 0

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define NVM_ADDR_RESET 6'h00
`define NVM_DATA_RESET 8'h00
`define NVM_CTRL_RESET 4'h0
`define NVM_DEPTH 64

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define NVM_LOW_SPEED_RC_OSC_KHZ 32
`define NVM_WRITE_TICKS 64
`define NVM_READ_CYCLES 4

`endif

// *** src/nvm_pkg.sv ***
// Purpose: Types shared by the byte memory block
// Assumes: Nothing
// Notes: Constants live in nvm_map.svh
package nvm_pkg;

	// ----------------------------------------------------------------
	// Access sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} access_state_e;

	typedef logic [5:0] byte_index_t;
	typedef logic [7:0] byte_value_t;

endpackage

// *** src/nvm_array_if.sv ***
// Purpose: Link between the access sequencer and the byte array
// Assumes: One clock
// Notes: Write strobe is a one-cycle pulse
interface nvm_array_if;
	logic rd_stb;
	logic wr_stb;
	nvm_pkg::byte_index_t nvm_byte_index;
	nvm_pkg::byte_value_t wr_value;
	nvm_pkg::byte_value_t rd_value;

	modport ctrl (
		output rd_stb,
		output wr_stb,
		output nvm_byte_index,
		output wr_value,
		input rd_value
	);

	modport mem (
		input rd_stb,
		input wr_stb,
		input nvm_byte_index,
		input wr_value,
		output rd_value
	);
endinterface

// *** src/nvm_byte_array.sv ***
// Purpose: 64 x 8 storage array with registered read port
// Assumes: Strobes come from the sequencer on the same clock
// Notes: Storage is not reset, it models retained content
`include "nvm_map.svh"

module nvm_byte_array (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Sequencer side
	nvm_array_if.mem port
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	nvm_pkg::byte_value_t cells [`NVM_DEPTH];
	nvm_pkg::byte_value_t rd_ff;
	nvm_pkg::byte_value_t nxt_rd;

	always_comb begin
		nxt_rd = rd_ff;
		if (port.rd_stb) begin
			nxt_rd = cells[port.nvm_byte_index];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ff <= `NVM_DATA_RESET;
		end else begin
			rd_ff <= nxt_rd;
		end
	end

	// Retained content, so no reset term
	always_ff @(posedge sys_clk_i) begin
		if (port.wr_stb) begin
			cells[port.nvm_byte_index] <= port.wr_value;
		end
	end

	assign port.rd_value = rd_ff;

endmodule // nvm_byte_array

// *** src/byte_eeprom_access_controller.sv ***
// Purpose: Byte-wide non-volatile memory access controller behind CPU special registers
// Assumes: Special register port driven by the CPU on sys_clk_i; low speed clock on a pin
// Notes: Write time counted in low speed clock edges, asynchronous to sys_clk_i
`include "nvm_map.svh"

module byte_eeprom_access_controller #(
	parameter int WRITE_TICKS = `NVM_WRITE_TICKS,
	parameter int READ_CYCLES = `NVM_READ_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Special register port
	input wire logic [7:0] pointer_high_byte_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Low speed clock and power mode
	input wire logic low_speed_rc_osc_i,
	input wire logic cpu_idle_i,
	// Interrupt hand-off
	input wire logic nvm_irq_mask_bit_i,
	input wire logic global_irq_enable_i,
	input wire logic stack_full_i,
	input wire logic irq_serviced_i,
	output logic nvm_irq_flag_o,
	output logic nvm_irq_req_o,
	// Status
	output logic busy_o
);

	// ----------------------------------------------------------------
	// Low speed clock synchroniser
	// ----------------------------------------------------------------
	logic [2:0] low_speed_rc_osc_ff;
	logic [2:0] nxt_low_speed_rc_osc;
	logic low_speed_rc_osc_lvl_ff;
	logic nxt_low_speed_rc_osc_lvl;
	logic low_speed_rc_osc_tick;

	// Level only moves once second and third stage agree
	always_comb begin
		nxt_low_speed_rc_osc = {low_speed_rc_osc_ff[1:0], low_speed_rc_osc_i};
		nxt_low_speed_rc_osc_lvl = low_speed_rc_osc_lvl_ff;
		if (low_speed_rc_osc_ff[1] == low_speed_rc_osc_ff[2]) begin
			nxt_low_speed_rc_osc_lvl = low_speed_rc_osc_ff[2];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_speed_rc_osc_ff <= 3'h0;
			low_speed_rc_osc_lvl_ff <= 1'b0;
		end else begin
			low_speed_rc_osc_ff <= nxt_low_speed_rc_osc;
			low_speed_rc_osc_lvl_ff <= nxt_low_speed_rc_osc_lvl;
		end
	end

	// Rising edge counted once, when both late stages agree on high
	assign low_speed_rc_osc_tick = low_speed_rc_osc_ff[2] & low_speed_rc_osc_ff[1] & ~low_speed_rc_osc_lvl_ff;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic ctrl_hit;
	logic addr_hit;
	logic data_hit;

	always_comb begin
		ctrl_hit = 1'b0;
		addr_hit = 1'b0;
		data_hit = 1'b0;
		// Control only through the sector 1 pointer window
		if (pointer_high_byte_i == `NVM_SECTOR_CTRL && sfr_addr_i == `NVM_CTRL_OFF) begin
			ctrl_hit = 1'b1;
		end else if (pointer_high_byte_i == `NVM_SECTOR_DIRECT
				&& sfr_addr_i == `NVM_ADDR_OFF) begin
			addr_hit = 1'b1;
		end else if (pointer_high_byte_i == `NVM_SECTOR_DIRECT
				&& sfr_addr_i == `NVM_DATA_OFF) begin
			data_hit = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer and registers
	// ----------------------------------------------------------------
	nvm_array_if arr ();

	nvm_pkg::access_state_e state_ff, nxt_state;
	nvm_pkg::byte_index_t nvm_addr_reg_ff, nxt_nvm_addr_reg;
	nvm_pkg::byte_value_t nvm_data_reg_ff, nxt_nvm_data_reg;
	logic program_permit_ff, nxt_program_permit;
	logic write_trig_ff, nxt_write_trig;
	logic fetch_permit_ff, nxt_fetch_permit;
	logic read_trig_ff, nxt_read_trig;
	logic irq_flag_ff, nxt_irq_flag;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [7:0] rdata_ff, nxt_rdata;
	logic write_done;
	logic [7:0] ctrl_view;

	assign ctrl_view = {4'h0, program_permit_ff, write_trig_ff, fetch_permit_ff,
		read_trig_ff};

	always_comb begin
		nxt_state = state_ff;
		nxt_nvm_addr_reg = nvm_addr_reg_ff;
		nxt_nvm_data_reg = nvm_data_reg_ff;
		nxt_program_permit = program_permit_ff;
		nxt_write_trig = write_trig_ff;
		nxt_fetch_permit = fetch_permit_ff;
		nxt_read_trig = read_trig_ff;
		nxt_cnt = cnt_ff;
		write_done = 1'b0;
		// Permits stay writable in any state
		if (sfr_wr_i && ctrl_hit) begin
			nxt_program_permit = sfr_wdata_i[`NVM_CTRL_PROGRAM_PERMIT];
			nxt_fetch_permit = sfr_wdata_i[`NVM_CTRL_FETCH_PERMIT];
		end
		case (state_ff)
			nvm_pkg::ST_IDLE: begin
				if (sfr_wr_i && addr_hit) begin
					nxt_nvm_addr_reg = sfr_wdata_i[5:0];
				end
				if (sfr_wr_i && data_hit) begin
					nxt_nvm_data_reg = sfr_wdata_i;
				end
				// Old permit value gates the trigger; two triggers at once start nothing
				if (sfr_wr_i && ctrl_hit && sfr_wdata_i[`NVM_CTRL_WRITE_TRIGGER]
						&& !sfr_wdata_i[`NVM_CTRL_READ_TRIGGER] && program_permit_ff) begin
					nxt_write_trig = 1'b1;
					nxt_cnt = 16'h0000;
					nxt_state = nvm_pkg::ST_WRITE;
				end else if (sfr_wr_i && ctrl_hit && sfr_wdata_i[`NVM_CTRL_READ_TRIGGER]
						&& !sfr_wdata_i[`NVM_CTRL_WRITE_TRIGGER] && fetch_permit_ff) begin
					nxt_read_trig = 1'b1;
					nxt_cnt = 16'h0000;
					nxt_state = nvm_pkg::ST_READ;
				end
			end
			nvm_pkg::ST_READ: begin
				nxt_cnt = cnt_ff + 16'h0001;
				if (cpu_idle_i || !fetch_permit_ff) begin
					nxt_read_trig = 1'b0;
					nxt_state = nvm_pkg::ST_IDLE;
				end else if (cnt_ff == 16'(READ_CYCLES)) begin
					nxt_nvm_data_reg = arr.rd_value;
					nxt_read_trig = 1'b0;
					nxt_state = nvm_pkg::ST_IDLE;
				end
			end
			nvm_pkg::ST_WRITE: begin
				if (low_speed_rc_osc_tick) begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
				if (cpu_idle_i || !program_permit_ff) begin
					nxt_write_trig = 1'b0;
					nxt_state = nvm_pkg::ST_IDLE;
				end else if (low_speed_rc_osc_tick && cnt_ff == 16'(WRITE_TICKS - 1)) begin
					write_done = 1'b1;
					nxt_write_trig = 1'b0;
					nxt_state = nvm_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = nvm_pkg::ST_IDLE;
			end
		endcase
		// Set beats a same-cycle service clear
		nxt_irq_flag = write_done | (irq_flag_ff & ~irq_serviced_i);
		nxt_rdata = rdata_ff;
		if (sfr_rd_i) begin
			if (ctrl_hit) begin
				nxt_rdata = ctrl_view;
			end else if (addr_hit) begin
				nxt_rdata = {2'b00, nvm_addr_reg_ff};
			end else if (data_hit) begin
				nxt_rdata = nvm_data_reg_ff;
			end else begin
				nxt_rdata = 8'h00;
			end
		end
	end

	// Trigger writes while busy fall through the busy states untouched
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= nvm_pkg::ST_IDLE;
			nvm_addr_reg_ff <= `NVM_ADDR_RESET;
			nvm_data_reg_ff <= `NVM_DATA_RESET;
			{program_permit_ff, write_trig_ff, fetch_permit_ff, read_trig_ff} <=
				`NVM_CTRL_RESET;
			irq_flag_ff <= 1'b0;
			cnt_ff <= 16'h0000;
			rdata_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			nvm_addr_reg_ff <= nxt_nvm_addr_reg;
			nvm_data_reg_ff <= nxt_nvm_data_reg;
			program_permit_ff <= nxt_program_permit;
			write_trig_ff <= nxt_write_trig;
			fetch_permit_ff <= nxt_fetch_permit;
			read_trig_ff <= nxt_read_trig;
			irq_flag_ff <= nxt_irq_flag;
			cnt_ff <= nxt_cnt;
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Array hookup
	// ----------------------------------------------------------------
	assign arr.rd_stb = (state_ff == nvm_pkg::ST_READ);
	assign arr.wr_stb = write_done;
	assign arr.nvm_byte_index = nvm_addr_reg_ff;
	assign arr.wr_value = nvm_data_reg_ff;

	nvm_byte_array u_array (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.port(arr.mem)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sfr_rdata_o = rdata_ff;
	assign nvm_irq_flag_o = irq_flag_ff;
	// Vector request only; the CPU does the actual vectoring
	assign nvm_irq_req_o = irq_flag_ff & nvm_irq_mask_bit_i & global_irq_enable_i
		& ~stack_full_i;
	assign busy_o = (state_ff != nvm_pkg::ST_IDLE);

endmodule // byte_eeprom_access_controller

// *** verif/nvm_access_props.sv ***
// Purpose: Port checks of the byte memory controller
// Assumes: One clock, reset active high
// Notes: Bound to the top module below
`include "nvm_map.svh"
module nvm_access_props (
	// Ports of the watched block
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] pointer_high_byte_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic cpu_idle_i,
	input wire logic nvm_irq_mask_bit_i,
	input wire logic global_irq_enable_i,
	input wire logic stack_full_i,
	input wire logic irq_serviced_i,
	input wire logic nvm_irq_flag_o,
	input wire logic nvm_irq_req_o,
	input wire logic busy_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	logic s0, idx_sel, ctl_sel, map_sel, ctl_wr;
	assign s0 = pointer_high_byte_i == `NVM_SECTOR_DIRECT;
	assign idx_sel = s0 && sfr_addr_i == `NVM_ADDR_OFF;
	assign ctl_sel = pointer_high_byte_i == `NVM_SECTOR_CTRL && sfr_addr_i == `NVM_CTRL_OFF;
	assign map_sel = idx_sel || ctl_sel || (s0 && sfr_addr_i == `NVM_DATA_OFF);
	assign ctl_wr = sfr_wr_i && ctl_sel;
	sequence s_ctl_rd;
		sfr_rd_i && ctl_sel;
	endsequence
	sequence s_idx_rd;
		sfr_rd_i && idx_sel;
	endsequence
	property p_unmapped; sfr_rd_i && !map_sel |=> sfr_rdata_o == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_idx_top; s_idx_rd |=> sfr_rdata_o[7:6] == 2'b00; endproperty
	a_idx_top: assert property (p_idx_top) else $error("index top bits set");
	property p_ctl_top; s_ctl_rd |=> sfr_rdata_o[7:4] == 4'h0; endproperty
	a_ctl_top: assert property (p_ctl_top) else $error("control top bits set");
	property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_req; nvm_irq_req_o == (nvm_irq_flag_o && nvm_irq_mask_bit_i &&
		global_irq_enable_i && !stack_full_i); endproperty
	a_req: assert property (p_req) else $error("request mismatch");
	// No start unless exactly one trigger is written
	property p_no_start; ctl_wr && !busy_o && sfr_wdata_i[2] == sfr_wdata_i[0] |=> !busy_o;
	endproperty
	a_no_start: assert property (p_no_start) else $error("cycle started");
	property p_flag_src; $rose(nvm_irq_flag_o) |-> $past(busy_o); endproperty
	a_flag_src: assert property (p_flag_src) else $error("flag without cycle");
	property p_clear; irq_serviced_i && !busy_o |=> !nvm_irq_flag_o; endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	property p_abort; busy_o && cpu_idle_i |=> !busy_o; endproperty
	a_abort: assert property (p_abort) else $error("idle did not abort");
	property p_trig_busy; busy_o ##0 s_ctl_rd ##1 busy_o |-> sfr_rdata_o[2] || sfr_rdata_o[0];
	endproperty
	a_trig_busy: assert property (p_trig_busy) else $error("trigger low while busy");
endmodule // nvm_access_props

bind byte_eeprom_access_controller nvm_access_props u_props (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pointer_high_byte_i(pointer_high_byte_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
	.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i),
	.nvm_irq_mask_bit_i(nvm_irq_mask_bit_i), .global_irq_enable_i(global_irq_enable_i),
	.stack_full_i(stack_full_i), .irq_serviced_i(irq_serviced_i),
	.nvm_irq_flag_o(nvm_irq_flag_o), .nvm_irq_req_o(nvm_irq_req_o), .busy_o(busy_o));

// *** verif/tb_byte_eeprom_access_controller.sv ***
// Purpose: Directed bench of the byte memory controller
// Assumes: Short write and read counts set at the instance
// Notes: Slow clock runs free, 40 system clocks a period, to keep the run short
`include "nvm_map.svh"
module tb_byte_eeprom_access_controller;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] S0 = `NVM_SECTOR_DIRECT;
	localparam logic [7:0] S1 = `NVM_SECTOR_CTRL;
	localparam logic [7:0] IX = `NVM_ADDR_OFF;
	localparam logic [7:0] DT = `NVM_DATA_OFF;
	localparam logic [7:0] CT = `NVM_CTRL_OFF;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] ph = 8'h00, ad = 8'h00, wd = 8'h00, rdata, rv;
	logic wr = 1'b0, rd = 1'b0, osc = 1'b0, idle = 1'b0, srv = 1'b0, flag, req, busy;
	logic gie = 1'b1, msk = 1'b1, stk = 1'b0;
	int miscompares = 0, n_tests = 0, tick = 0;
	always #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		tick <= (tick == 19) ? 0 : tick + 1;
		if (tick == 19) osc <= ~osc;
	end
	byte_eeprom_access_controller #(.WRITE_TICKS(3), .READ_CYCLES(1)) u_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pointer_high_byte_i(ph), .sfr_addr_i(ad),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
		.low_speed_rc_osc_i(osc), .cpu_idle_i(idle), .nvm_irq_mask_bit_i(msk),
		.global_irq_enable_i(gie), .stack_full_i(stk), .irq_serviced_i(srv),
		.nvm_irq_flag_o(flag), .nvm_irq_req_o(req), .busy_o(busy));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Second byte differing from the first makes a back-to-back pair
	task automatic put(input logic [7:0] p, a, d1, d2);
		ph <= p;
		ad <= a;
		wd <= d1;
		wr <= 1'b1;
		@(posedge sys_clk_i);
		if (d2 !== d1) begin
			wd <= d2;
			@(posedge sys_clk_i);
		end
		wr <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic gc(input logic [7:0] p, a, e, input bit ck = 1'b1);
		ph <= p;
		ad <= a;
		rd <= 1'b1;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		@(negedge sys_clk_i);
		rv = rdata;
		@(posedge sys_clk_i);
		if (ck) chk(rv, e);
	endtask
	task automatic poll(input int b, output int n);
		n = 0;
		do begin
			gc(S1, CT, 8'h00, 1'b0);
			n++;
		end while (rv[b] === 1'b1 && n < 200);
	endtask
	task automatic t_regs();
		gc(S0, IX, 8'h00);
		gc(S0, DT, 8'h00);
		gc(S1, CT, 8'h00);
		put(S0, IX, 8'hff, 8'hff);
		gc(S0, IX, 8'h3f);
		put(S1, CT, 8'hf0, 8'hf0);
		gc(S1, CT, 8'h00);
		put(S0, CT, 8'h0a, 8'h0a);
		gc(S1, CT, 8'h00);
		gc(S0, CT, 8'h00);
	endtask
	task automatic t_write(input logic [7:0] i, v);
		int n;
		put(S0, IX, i, i);
		put(S0, DT, v, v);
		gie <= 1'b0;
		put(S1, CT, 8'h08, 8'h0c);
		gie <= 1'b1;
		gc(S1, CT, 8'h0c);
		poll(2, n);
		chk(rv, 8'h08);
		chk(8'(n > 10), 8'h01);
		chk({6'h00, flag, req}, 8'h03);
		stk <= 1'b1;
		@(negedge sys_clk_i);
		chk({7'h00, req}, 8'h00);
		@(posedge sys_clk_i);
		stk <= 1'b0;
		msk <= 1'b0;
		@(negedge sys_clk_i);
		chk({7'h00, req}, 8'h00);
		@(posedge sys_clk_i);
		msk <= 1'b1;
		srv <= 1'b1;
		@(posedge sys_clk_i);
		srv <= 1'b0;
		@(negedge sys_clk_i);
		chk({7'h00, flag}, 8'h00);
		@(posedge sys_clk_i);
	endtask
	task automatic t_read(input logic [7:0] i, v);
		int n;
		put(S0, IX, i, i);
		put(S1, CT, 8'h02, 8'h03);
		poll(0, n);
		chk(rv, 8'h02);
		gc(S0, DT, v);
		gc(S0, IX, i);
	endtask
	task automatic t_refuse();
		put(S1, CT, 8'h04, 8'h04);
		gc(S1, CT, 8'h00);
		put(S1, CT, 8'h01, 8'h01);
		gc(S1, CT, 8'h00);
		put(S1, CT, 8'h0a, 8'h0f);
		gc(S1, CT, 8'h0a);
		put(S0, DT, 8'h77, 8'h77);
		put(S1, CT, 8'h00, 8'h04);
		t_read(8'h05, 8'h5a);
	endtask
	// Idle lands well inside the write, long before three slow edges
	task automatic t_abort();
		put(S0, DT, 8'h33, 8'h33);
		put(S1, CT, 8'h08, 8'h0c);
		put(S1, CT, 8'h0b, 8'h0b);
		gc(S1, CT, 8'h0e);
		repeat (5) @(posedge sys_clk_i);
		idle <= 1'b1;
		@(posedge sys_clk_i);
		idle <= 1'b0;
		gc(S1, CT, 8'h0a);
		chk({7'h00, flag}, 8'h00);
		t_read(8'h05, 8'h5a);
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_regs();
		t_write(8'h05, 8'h5a);
		t_write(8'h3f, 8'hc3);
		t_read(8'h05, 8'h5a);
		t_read(8'h3f, 8'hc3);
		t_refuse();
		t_abort();
		report_and_stop();
	end
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule // tb_byte_eeprom_access_controller
